// *** src/rsc_glitch_filter.sv ***
module rsc_glitch_filter #(
   parameter int unsigned MIN_CYC = rsc_pkg::GLITCH_MIN_CYC,
   parameter int unsigned CNT_W = 8
) (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   // pin and result
   input wire logic pin_n_i,
   output logic low_o
);
   if (MIN_CYC < 1 || MIN_CYC >= (1 << CNT_W)) begin : g_bad_min
      $error("glitch filter count out of range");
   end

   localparam logic [CNT_W-1:0] MIN_VAL = CNT_W'(MIN_CYC);

   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] cnt_next;
   logic low_reg;
   logic low_next;

   // ----------------------------------------
   // count consecutive low cycles
   // ----------------------------------------
   always_comb begin
      cnt_next = cnt_reg;
      low_next = low_reg;
      if (pin_n_i) begin
         cnt_next = '0;
         low_next = 1'b0;
      end else if (cnt_reg < MIN_VAL) begin
         cnt_next = cnt_reg + 1'b1;
      end else begin
         low_next = 1'b1;
      end
   end

   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cnt_reg <= '0;
         low_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         low_reg <= low_next;
      end
   end

   assign low_o = low_reg;

   pin_release_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      pin_n_i |=> !low_o) else $error("filter held low after pin rose");
endmodule

// *** src/rsc_pkg.sv ***
package rsc_pkg;
   // ----------------------------------------
   // reset cause register layout
   // ----------------------------------------
   localparam int unsigned CAUSE_W = 16;
   localparam logic [CAUSE_W-1:0] CAUSE_RST_VAL = 16'h0000;
   localparam int unsigned EXT_PIN_BIT = 7;
   localparam int unsigned SOFT_BIT = 6;
   localparam int unsigned WDOG_BIT = 4;
   localparam int unsigned ILLEGAL_BIT = 14;
   localparam int unsigned TRAP_BIT = 15;

   // ----------------------------------------
   // instruction decode and traps
   // ----------------------------------------
   localparam int unsigned INSTR_W = 24;
   localparam int unsigned OPC_HI = 23;
   localparam int unsigned OPC_LO = 16;
   localparam logic [7:0] ILLEGAL_OPCODE = 8'h3f;
   localparam int unsigned TRAP_LVL_W = 4;
   localparam logic [TRAP_LVL_W-1:0] HARD_TRAP_MIN = 4'hd;
   localparam logic [TRAP_LVL_W-1:0] HARD_TRAP_MAX = 4'hf;
   localparam logic [TRAP_LVL_W-1:0] ADDR_ERR_LVL = 4'hd;
   localparam logic [TRAP_LVL_W-1:0] OSC_ERR_LVL = 4'he;

   // ----------------------------------------
   // working register array
   // ----------------------------------------
   localparam int unsigned WREG_N = 16;
   localparam int unsigned WREG_IDX_W = 4;
   localparam logic [WREG_IDX_W-1:0] STACK_PTR_IDX = 4'hf;

   // ----------------------------------------
   // timing counts
   // ----------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 5;
   localparam int unsigned INSTR_CYC_NS = 10;
   localparam int unsigned INSTR_DIV = (INSTR_CYC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned GLITCH_MIN_NS = 40;
   localparam int unsigned GLITCH_MIN_CYC = (GLITCH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ----------------------------------------
   // sequencer states
   // ----------------------------------------
   typedef enum logic [1:0] {
      RSC_RUN = 2'b00,
      RSC_HOLD = 2'b01,
      RSC_VECTOR = 2'b11
   } rsc_state_t;
endpackage

// *** src/rsc_top.sv ***
module rsc_top #(
   parameter int unsigned GLITCH_CYC = rsc_pkg::GLITCH_MIN_CYC,
   parameter int unsigned DIV_CYC = rsc_pkg::INSTR_DIV
) (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   // external pin
   input wire logic master_clear_pin_n_i,
   // core events
   input wire logic soft_reset_instr_i,
   input wire logic instr_valid_i,
   input wire logic [rsc_pkg::INSTR_W-1:0] instr_word_i,
   input wire logic security_violation_i,
   input wire logic sleep_i,
   input wire logic idle_i,
   // watchdog
   input wire logic watchdog_timer_timeout_i,
   // traps
   input wire logic trap_req_i,
   input wire logic [rsc_pkg::TRAP_LVL_W-1:0] trap_level_i,
   input wire logic trap_busy_i,
   input wire logic [rsc_pkg::TRAP_LVL_W-1:0] trap_busy_level_i,
   // working registers
   input wire logic wreg_wr_i,
   input wire logic [rsc_pkg::WREG_IDX_W-1:0] wreg_wr_idx_i,
   input wire logic wreg_ptr_use_i,
   input wire logic [rsc_pkg::WREG_IDX_W-1:0] wreg_ptr_idx_i,
   // cause flag clearing
   input wire logic cause_clr_i,
   input wire logic [rsc_pkg::CAUSE_W-1:0] cause_clr_mask_i,
   // outputs
   output logic system_reset_o,
   output logic vector_fetch_o,
   output logic clk_reinit_o,
   output logic wake_o,
   output logic wreg_clear_o,
   output logic [rsc_pkg::CAUSE_W-1:0] reset_cause_register_o
);
   if (DIV_CYC < 1 || DIV_CYC > 255) begin : g_bad_div
      $error("instruction divider out of range");
   end

   localparam int REL_MAX = 64;
   localparam logic [7:0] DIV_LAST = 8'(DIV_CYC - 1);

   // ----------------------------------------
   // master clear filter and register tracker
   // ----------------------------------------
   logic pin_low;
   rsc_wreg_if wif ();

   rsc_glitch_filter #(
      .MIN_CYC(GLITCH_CYC)
   ) u_filter (
      .core_clk_i(core_clk_i),
      .sys_rst_i(sys_rst_i),
      .pin_n_i(master_clear_pin_n_i),
      .low_o(pin_low)
   );

   rsc_wreg_track u_track (
      .core_clk_i(core_clk_i),
      .sys_rst_i(sys_rst_i),
      .wif(wif)
   );

   // ----------------------------------------
   // instruction cycle divider
   // ----------------------------------------
   logic [7:0] div_reg;
   logic [7:0] div_next;
   logic instr_en;

   always_comb begin
      instr_en = (div_reg == DIV_LAST);
      div_next = instr_en ? 8'h00 : div_reg + 8'h01;
   end

   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         div_reg <= 8'h00;
      end else begin
         div_reg <= div_next;
      end
   end

   // ----------------------------------------
   // cause detection
   // ----------------------------------------
   logic run;
   logic sleeping;
   logic wdog_rst_evt;
   logic wake_evt;
   logic hard_trap;
   logic trap_evt;
   logic illop_evt;
   logic illegal_evt;
   logic any_evt;
   rsc_pkg::rsc_state_t state_reg;
   rsc_pkg::rsc_state_t state_next;

   always_comb begin
      run = (state_reg == rsc_pkg::RSC_RUN);
      sleeping = sleep_i || idle_i;
      wdog_rst_evt = run && watchdog_timer_timeout_i && !sleeping;
      wake_evt = run && watchdog_timer_timeout_i && sleeping;
      hard_trap = (trap_level_i >= rsc_pkg::HARD_TRAP_MIN) && (trap_level_i <= rsc_pkg::HARD_TRAP_MAX);
      trap_evt = run && trap_req_i && hard_trap && trap_busy_i && (trap_level_i < trap_busy_level_i);
      illop_evt = instr_valid_i && (instr_word_i[rsc_pkg::OPC_HI:rsc_pkg::OPC_LO] == rsc_pkg::ILLEGAL_OPCODE);
      illegal_evt = run && (illop_evt || wif.fault || security_violation_i);
      any_evt = (run && soft_reset_instr_i) || wdog_rst_evt || trap_evt || illegal_evt;
   end

   // ----------------------------------------
   // reset sequencer
   // ----------------------------------------
   logic rst_out_reg;
   logic rst_out_next;
   logic vec_reg;
   logic vec_next;
   logic clk_reg;
   logic clk_next;
   logic wake_reg;
   logic wake_next;
   logic wclr_reg;
   logic wclr_next;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         rsc_pkg::RSC_RUN: begin
            if (pin_low || any_evt) begin
               state_next = rsc_pkg::RSC_HOLD;
            end
         end
         rsc_pkg::RSC_HOLD: begin
            if (!pin_low && instr_en) begin
               state_next = rsc_pkg::RSC_VECTOR;
            end
         end
         rsc_pkg::RSC_VECTOR: begin
            state_next = pin_low ? rsc_pkg::RSC_HOLD : rsc_pkg::RSC_RUN;
         end
         default: begin
            state_next = rsc_pkg::RSC_HOLD;
         end
      endcase
      rst_out_next = (state_next == rsc_pkg::RSC_HOLD);
      vec_next = (state_next == rsc_pkg::RSC_VECTOR);
      clk_next = pin_low && (state_reg != rsc_pkg::RSC_HOLD);
      wake_next = wake_evt;
      wclr_next = (state_next == rsc_pkg::RSC_HOLD) && (state_reg != rsc_pkg::RSC_HOLD);
   end

   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state_reg <= rsc_pkg::RSC_HOLD;
         rst_out_reg <= 1'b1;
         vec_reg <= 1'b0;
         clk_reg <= 1'b0;
         wake_reg <= 1'b0;
         wclr_reg <= 1'b1;
      end else begin
         state_reg <= state_next;
         rst_out_reg <= rst_out_next;
         vec_reg <= vec_next;
         clk_reg <= clk_next;
         wake_reg <= wake_next;
         wclr_reg <= wclr_next;
      end
   end

   assign wif.clear = wclr_reg || rst_out_reg;
   assign wif.wr_stb = wreg_wr_i;
   assign wif.wr_idx = wreg_wr_idx_i;
   assign wif.use_stb = wreg_ptr_use_i && run;
   assign wif.use_idx = wreg_ptr_idx_i;

   // ----------------------------------------
   // reset cause flags
   // ----------------------------------------
   logic [rsc_pkg::CAUSE_W-1:0] cause_reg;
   logic [rsc_pkg::CAUSE_W-1:0] cause_next;
   logic [rsc_pkg::CAUSE_W-1:0] cause_set;

   always_comb begin
      cause_set = '0;
      cause_set[rsc_pkg::EXT_PIN_BIT] = pin_low;
      cause_set[rsc_pkg::SOFT_BIT] = run && soft_reset_instr_i;
      cause_set[rsc_pkg::WDOG_BIT] = wdog_rst_evt;
      cause_set[rsc_pkg::TRAP_BIT] = trap_evt;
      cause_set[rsc_pkg::ILLEGAL_BIT] = illegal_evt;
      cause_next = cause_reg;
      if (cause_clr_i) begin
         cause_next = cause_reg & ~cause_clr_mask_i;
      end
      cause_next = cause_next | cause_set;
   end

   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cause_reg <= rsc_pkg::CAUSE_RST_VAL;
      end else begin
         cause_reg <= cause_next;
      end
   end

   assign system_reset_o = rst_out_reg;
   assign vector_fetch_o = vec_reg;
   assign clk_reinit_o = clk_reg;
   assign wake_o = wake_reg;
   assign wreg_clear_o = wclr_reg;
   assign reset_cause_register_o = cause_reg;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   ext_reset_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      pin_low |=> system_reset_o) else $error("pin low without system reset");

   ext_flag_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      pin_low |=> reset_cause_register_o[rsc_pkg::EXT_PIN_BIT]) else $error("external pin flag not set");

   soft_enter_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      (run && soft_reset_instr_i) |=> system_reset_o) else $error("soft reset not asserted");

   soft_release_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      (state_reg == rsc_pkg::RSC_HOLD && !pin_low && instr_en) |=> (!system_reset_o && vector_fetch_o)
      ##1 !vector_fetch_o) else $error("reset release or vector fetch wrong");

   soft_bounded_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      (run && soft_reset_instr_i && master_clear_pin_n_i) ##1 master_clear_pin_n_i [*2]
      |-> ##[1:REL_MAX] (vector_fetch_o || pin_low)) else $error("soft reset never released");

   soft_clock_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      (run && !pin_low && (soft_reset_instr_i || wdog_rst_evt)) |=> !clk_reinit_o)
      else $error("clock reinitialised by soft or watchdog reset");

   ext_clock_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      (run && pin_low) |=> clk_reinit_o) else $error("pin reset did not reinitialise clock");

   soft_flag_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      (run && soft_reset_instr_i) |=> reset_cause_register_o[rsc_pkg::SOFT_BIT]) else $error("soft flag missing");

   wdog_reset_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      (run && watchdog_timer_timeout_i && !sleep_i && !idle_i) |=> system_reset_o && !wake_o)
      else $error("watchdog reset missing");

   wdog_wake_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      (run && watchdog_timer_timeout_i && (sleep_i || idle_i) && !pin_low && !soft_reset_instr_i &&
       !trap_evt && !illegal_evt) |=> (wake_o && !system_reset_o &&
       reset_cause_register_o[rsc_pkg::WDOG_BIT] == $past(reset_cause_register_o[rsc_pkg::WDOG_BIT])))
      else $error("watchdog in sleep reset the core");

   wdog_flag_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      wdog_rst_evt |=> reset_cause_register_o[rsc_pkg::WDOG_BIT]) else $error("watchdog flag missing");

   trap_conflict_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      (run && trap_req_i && trap_busy_i && trap_level_i >= rsc_pkg::ADDR_ERR_LVL &&
       trap_level_i < trap_busy_level_i) |=> (system_reset_o && reset_cause_register_o[rsc_pkg::TRAP_BIT]))
      else $error("trap conflict not reset");

   soft_trap_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      (trap_req_i && trap_level_i < rsc_pkg::HARD_TRAP_MIN) |-> !trap_evt) else $error("soft trap caused conflict");

   illop_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      (run && instr_valid_i && instr_word_i[rsc_pkg::OPC_HI:rsc_pkg::OPC_LO] == rsc_pkg::ILLEGAL_OPCODE)
      |=> (system_reset_o && reset_cause_register_o[rsc_pkg::ILLEGAL_BIT])) else $error("illegal opcode missed");

   flag_keep_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      (reset_cause_register_o[rsc_pkg::SOFT_BIT] && !(cause_clr_i && cause_clr_mask_i[rsc_pkg::SOFT_BIT]))
      |=> reset_cause_register_o[rsc_pkg::SOFT_BIT]) else $error("cause flag lost");

   wreg_clear_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      $rose(system_reset_o) |-> wreg_clear_o) else $error("registers not cleared on reset");

   sec_reset_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      (run && security_violation_i) |=> (system_reset_o && reset_cause_register_o[rsc_pkg::ILLEGAL_BIT]))
      else $error("security violation not reset");

   uninit_reset_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      (run && wif.fault) |=> (system_reset_o && reset_cause_register_o[rsc_pkg::ILLEGAL_BIT]))
      else $error("uninitialized pointer reset missing");

   osc_trap_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      (run && trap_req_i && trap_busy_i && trap_level_i == rsc_pkg::OSC_ERR_LVL &&
       trap_busy_level_i > rsc_pkg::OSC_ERR_LVL) |=> system_reset_o) else $error("oscillator trap conflict missed");
endmodule

// *** src/rsc_wreg_if.sv ***
interface rsc_wreg_if;
   logic clear;
   logic wr_stb;
   logic [rsc_pkg::WREG_IDX_W-1:0] wr_idx;
   logic use_stb;
   logic [rsc_pkg::WREG_IDX_W-1:0] use_idx;
   logic fault;

   modport tracker (
      input clear,
      input wr_stb,
      input wr_idx,
      input use_stb,
      input use_idx,
      output fault
   );

   modport core (
      output clear,
      output wr_stb,
      output wr_idx,
      output use_stb,
      output use_idx,
      input fault
   );
endinterface

// *** src/rsc_wreg_track.sv ***
module rsc_wreg_track (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   // core side
   rsc_wreg_if.tracker wif
);
   logic [rsc_pkg::WREG_N-1:0] init_reg;
   logic [rsc_pkg::WREG_N-1:0] init_next;
   logic fault_reg;
   logic fault_next;

   // ----------------------------------------
   // written-since-reset tracking
   // ----------------------------------------
   always_comb begin
      init_next = init_reg;
      fault_next = 1'b0;
      if (wif.clear) begin
         init_next = '0;
      end else begin
         if (wif.use_stb && !init_reg[wif.use_idx]) begin
            fault_next = 1'b1;
         end
         if (wif.wr_stb) begin
            init_next[wif.wr_idx] = 1'b1;
         end
      end
      init_next[rsc_pkg::STACK_PTR_IDX] = 1'b1;
   end

   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         init_reg <= {rsc_pkg::WREG_N{1'b0}};
         fault_reg <= 1'b0;
      end else begin
         init_reg <= init_next;
         fault_reg <= fault_next;
      end
   end

   assign wif.fault = fault_reg;

   // ----------------------------------------
   // check helper: any write since the last clear
   // ----------------------------------------
   logic wr_seen_reg;
   logic wr_seen_next;

   always_comb begin
      wr_seen_next = wr_seen_reg;
      if (wif.clear) begin
         wr_seen_next = 1'b0;
      end else if (wif.wr_stb) begin
         wr_seen_next = 1'b1;
      end
   end

   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         wr_seen_reg <= 1'b0;
      end else begin
         wr_seen_reg <= wr_seen_next;
      end
   end

   uninit_use_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      (!wif.clear && !wr_seen_reg && wif.use_stb && wif.use_idx != rsc_pkg::STACK_PTR_IDX)
      |=> wif.fault) else $error("uninitialized pointer use not flagged");

   sp_kept_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      (wif.use_stb && wif.use_idx == rsc_pkg::STACK_PTR_IDX)
      |=> !wif.fault) else $error("stack pointer treated as uninitialized");
endmodule

// *** test/rsc_core_model.sv ***
module rsc_core_model (
   // clock
   input wire logic core_clk_i,
   // pin and core events
   output logic pin_n_o,
   output logic soft_o,
   output logic ivalid_o,
   output logic [23:0] iword_o,
   output logic sec_o,
   output logic sleep_o,
   output logic idle_o,
   output logic wdog_o,
   // traps
   output logic trq_o,
   output logic [3:0] tlvl_o,
   output logic tbusy_o,
   output logic [3:0] tblvl_o,
   // working registers and flag clearing
   output logic wwr_o,
   output logic [3:0] widx_o,
   output logic puse_o,
   output logic [3:0] pidx_o,
   output logic clr_o,
   output logic [15:0] cmask_o
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      {pin_n_o, soft_o, ivalid_o, sec_o, sleep_o, idle_o, wdog_o} = 7'h40;
      {trq_o, tbusy_o, wwr_o, puse_o, clr_o} = 5'h00;
      {iword_o, tlvl_o, tblvl_o, widx_o, pidx_o, cmask_o} = 56'h0;
   end

   // ----------------------------------------
   // one request, set after a falling edge and held a full cycle
   // ----------------------------------------
   task automatic drive(input logic [3:0] op, input logic [23:0] arg);
      @(negedge core_clk_i);
      case (op)
         4'h0: soft_o = 1'b1;
         4'h1: wdog_o = 1'b1;
         4'h2: {ivalid_o, iword_o} = {1'b1, arg};
         4'h3: sec_o = 1'b1;
         4'h4: {trq_o, tbusy_o, tblvl_o, tlvl_o} = {2'b11, arg[7:0]};
         4'h5: {wwr_o, widx_o} = {1'b1, arg[3:0]};
         4'h6: {puse_o, pidx_o} = {1'b1, arg[3:0]};
         4'h7: {clr_o, cmask_o} = {1'b1, arg[15:0]};
         4'h8: {sleep_o, idle_o} = arg[1:0];
         4'h9: begin
            pin_n_o = 1'b0;
            repeat (arg) @(negedge core_clk_i);
            pin_n_o = 1'b1;
         end
         default: ;
      endcase
      @(negedge core_clk_i);
      {soft_o, ivalid_o, sec_o, wdog_o, trq_o, tbusy_o, wwr_o, puse_o, clr_o} = 9'h0;
      // released data lines show the inverse of their last value
      {iword_o, tlvl_o, tblvl_o} = ~{iword_o, tlvl_o, tblvl_o};
      {widx_o, pidx_o, cmask_o} = ~{widx_o, pidx_o, cmask_o};
   endtask
endmodule

// *** test/tb.sv ***
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned GCYC = 3;
   logic core_clk_i, sys_rst_i, prev_rst;
   logic master_clear_pin_n_i, soft_reset_instr_i, instr_valid_i, security_violation_i, sleep_i, idle_i;
   logic watchdog_timer_timeout_i, trap_req_i, trap_busy_i, wreg_wr_i, wreg_ptr_use_i, cause_clr_i;
   logic [23:0] instr_word_i;
   logic [3:0] trap_level_i, trap_busy_level_i, wreg_wr_idx_i, wreg_ptr_idx_i;
   logic [15:0] cause_clr_mask_i, reset_cause_register_o;
   logic system_reset_o, vector_fetch_o, clk_reinit_o, wake_o, wreg_clear_o;
   logic [17:0] notes[$];
   logic [17:0] head;
   int n_mismatch, checked, k, w;

   rsc_top #(.GLITCH_CYC(GCYC), .DIV_CYC(2)) rsc_top_i (
      .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .master_clear_pin_n_i(master_clear_pin_n_i),
      .soft_reset_instr_i(soft_reset_instr_i), .instr_valid_i(instr_valid_i), .instr_word_i(instr_word_i),
      .security_violation_i(security_violation_i), .sleep_i(sleep_i), .idle_i(idle_i),
      .watchdog_timer_timeout_i(watchdog_timer_timeout_i), .trap_req_i(trap_req_i), .trap_level_i(trap_level_i),
      .trap_busy_i(trap_busy_i), .trap_busy_level_i(trap_busy_level_i), .wreg_wr_i(wreg_wr_i),
      .wreg_wr_idx_i(wreg_wr_idx_i), .wreg_ptr_use_i(wreg_ptr_use_i), .wreg_ptr_idx_i(wreg_ptr_idx_i),
      .cause_clr_i(cause_clr_i), .cause_clr_mask_i(cause_clr_mask_i), .system_reset_o(system_reset_o),
      .vector_fetch_o(vector_fetch_o), .clk_reinit_o(clk_reinit_o), .wake_o(wake_o),
      .wreg_clear_o(wreg_clear_o), .reset_cause_register_o(reset_cause_register_o));

   rsc_core_model rsc_core_model_i (
      .core_clk_i(core_clk_i), .pin_n_o(master_clear_pin_n_i), .soft_o(soft_reset_instr_i),
      .ivalid_o(instr_valid_i), .iword_o(instr_word_i), .sec_o(security_violation_i),
      .sleep_o(sleep_i), .idle_o(idle_i), .wdog_o(watchdog_timer_timeout_i),
      .trq_o(trap_req_i), .tlvl_o(trap_level_i), .tbusy_o(trap_busy_i), .tblvl_o(trap_busy_level_i),
      .wwr_o(wreg_wr_i), .widx_o(wreg_wr_idx_i), .puse_o(wreg_ptr_use_i), .pidx_o(wreg_ptr_idx_i),
      .clr_o(cause_clr_i), .cmask_o(cause_clr_mask_i));

   initial begin
      core_clk_i = 1'b0;
      forever #2.5 core_clk_i = ~core_clk_i;
   end

   // ----------------------------------------
   // comparison and verdict
   // ----------------------------------------
   task automatic check(input logic [17:0] seen, input logic [17:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic finish_test();
      check(18'(notes.size()), 18'h0);
      $display("mismatches %0d checks %0d", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   // ----------------------------------------
   // scenario helpers
   // ----------------------------------------
   task automatic wait_vec();
      k = 0;
      while (vector_fetch_o !== 1'b1 && k < 12) begin
         @(negedge core_clk_i);
         k++;
      end
      check(18'(k < 12), 18'h1);
   endtask

   task automatic settle(input logic [17:0] n);
      if (n[15:0] != 16'h0) begin
         wait_vec();
         check(18'(reset_cause_register_o), 18'(n[15:0]));
         rsc_core_model_i.drive(4'h7, 24'(~n[15:0]));
         check(18'(reset_cause_register_o), 18'(n[15:0]));
         rsc_core_model_i.drive(4'h7, 24'hffff);
         check(18'(reset_cause_register_o), 18'h0);
      end else begin
         repeat (6) @(negedge core_clk_i);
         check(18'(system_reset_o), 18'h0);
      end
   endtask

   task automatic ev(input logic [3:0] op, input logic [23:0] arg, input logic [17:0] n);
      if (n != 18'h0) notes.push_back(n);
      rsc_core_model_i.drive(op, arg);
      settle(n);
   endtask

   // ----------------------------------------
   // result watcher
   // ----------------------------------------
   always @(negedge core_clk_i) begin
      if (!sys_rst_i && ((system_reset_o && !prev_rst) || wake_o)) begin
         head = (notes.size() > 0) ? notes.pop_front() : 18'h3ffff;
         check({wake_o, clk_reinit_o, reset_cause_register_o}, head);
         check(18'(wreg_clear_o), 18'(system_reset_o));
      end
      prev_rst = system_reset_o;
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      n_mismatch = 0;
      checked = 0;
      prev_rst = 1'b1;
      sys_rst_i = 1'b1;
      void'($urandom(32'h6c94));
      repeat (8) @(posedge core_clk_i);
      @(negedge core_clk_i);
      sys_rst_i = 1'b0;
      wait_vec();
      ev(4'h0, 24'h0, 18'h00040);
      ev(4'h1, 24'h0, 18'h00010);
      for (int s = 1; s < 3; s++) begin
         ev(4'h8, 24'(s), 18'h0);
         ev(4'h1, 24'h0, 18'h20000);
      end
      ev(4'h8, 24'h0, 18'h0);
      ev(4'h4, 24'hfd, 18'h08000);
      ev(4'h4, 24'hfe, 18'h08000);
      ev(4'h4, 24'hed, 18'h08000);
      ev(4'h4, 24'hfc, 18'h0);
      ev(4'h4, 24'hdf, 18'h0);
      ev(4'h4, 24'hee, 18'h0);
      ev(4'h2, {8'h3f, 16'($urandom)}, 18'h04000);
      ev(4'h2, {8'($urandom_range(0, 62)), 16'($urandom)}, 18'h0);
      ev(4'h3, 24'h0, 18'h04000);
      w = $urandom_range(0, 14);
      ev(4'h5, 24'(w), 18'h0);
      ev(4'h6, 24'(w), 18'h0);
      ev(4'h6, 24'hf, 18'h0);
      ev(4'h6, 24'((w + 1) % 15), 18'h04000);
      ev(4'h6, 24'(w), 18'h04000);
      ev(4'h9, 24'(GCYC), 18'h0);
      ev(4'h9, 24'(GCYC * 3), 18'h10080);
      finish_test();
   end

   initial begin
      #20us;
      n_mismatch++;
      finish_test();
   end
endmodule
